// *** e1_cfg_defines.vh ***
`ifndef E1_CFG_DEFINES_VH
`define E1_CFG_DEFINES_VH

// timing
`define CLK_HZ            10000000
`define BAUD_RATE         9600
`define BAUD_DIV          ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define STATS_PERIOD_S    1
`define STATS_CYCLES      (`CLK_HZ * `STATS_PERIOD_S)
`define DEBOUNCE_MS       5
`define DEBOUNCE_CYCLES   (`CLK_HZ / 1000 * `DEBOUNCE_MS)

// register byte offsets
`define REG_PENDING       8'h00
`define REG_ACTIVE        8'h04
`define REG_STATUS        8'h08
`define REG_COMMAND       8'h0c
`define REG_CRC_STAT      8'h10
`define REG_PW_WORD0      8'h14
`define REG_PW_WORD3      8'h20
`define REG_PW_LENGTH     8'h24

// config field positions
`define CFG_LINE_CODE     0
`define CFG_CAS           1
`define CFG_CRC_CLK       2
`define CFG_CLK_SEL       3
`define CFG_RATE_LSB      4
`define CFG_RESET         8'h00

// status bits
`define ST_LOGGED_IN      0
`define ST_BLANK          1
`define ST_LOS            2
`define ST_RATE_INVALID   3
`define ST_UNSAVED        4
`define ST_CRC_EXCESS     5
`define ST_RATE_CONFLICT  6

// command bits
`define CMD_SAVE          0
`define CMD_LOGOFF        1

// clock modes
`define CLK_NETWORK       2'h0
`define CLK_INTERNAL      2'h1
`define CLK_EXTERNAL      2'h2

// terminal characters
`define CH_ENTER          8'h0d
`define CH_STAR           8'h2a
`define CH_PROMPT         8'h3a
`define CH_MENU           8'h3e
`define CH_BLANK          8'h0c
`define CH_XON            8'h11
`define CH_XOFF           8'h13
`define CH_SAVE           8'h64
`define CH_LOGOFF         8'h65
`define PW_MAX            16
`define DEFAULT_PW_LEN    5'h00

`endif

// *** e1_switch_config_decoder.v ***
// Function
// - line code switch off selects HDB3, on selects AMI.
// - HDB3 mode: transmit violations replace zero runs, receiver restores zeros.
// - CAS multiframe is 16 frames of 32 timeslots, numbered 0 to 31.
// - with CAS, frame 0 TS16 upper four bits carry alignment word 0000.
// - besides alignment word, no own signaling is placed in TS16.
// - CAS off gives TS16 to user (31 channels); on withholds it (30).
// - both ends match CAS setting, else CAS-enabled end reports loss of sync.
// - framed CRC switch enables CRC-4 multiframe in TS0, independent of CAS.
// - CRC-4 on checks errors and returns error counts to far end.
// - both ends match CRC-4 setting, else CRC-enabled end detects loss of sync.
// - framed: clock switch alone picks network (off) or internal (on).
// - unframed: crc/clock switches 00 net, 01 int, 11 ext, 10 net.
// - network timing recovered from line; internal from on-board source.
// - external timing comes from DTE, only in unframed operation.
// - four rate switches form code, first is LSB; 15 invalid.
// - clear channel: unframed, all 32 timeslots, CAS and CRC ignored.
// - all other rates use framing with TS0 reserved.
// - control port runs 9600 baud 8N1 with XON/XOFF flow control.
// - password up to 16 chars, case exact, star echo, wrong clears and reprompts.
// - performance statistics refresh once every second.
// - port changes stay unsaved until save, which writes nonvolatile memory.
// - logoff blanks terminal until Enter arrives.
// - switch changes apply at once without save.
`timescale 1ns/1ps
`include "e1_cfg_defines.vh"
module e1_switch_config_decoder
#(
    parameter STATS_CYCLES    = `STATS_CYCLES,
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter CRC_EXCESS      = 16'h03e8
)
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // configuration switches
    input  wire        line_code_switch,
    input  wire        cas_multiframe_switch,
    input  wire        crc_or_clock_high_switch,
    input  wire        clock_select_switch,
    input  wire        rate_code_bit0,
    input  wire        rate_code_bit1,
    input  wire        rate_code_bit2,
    input  wire        rate_code_bit3,
    // serial control port
    input  wire        ctl_rxd,
    output reg         ctl_txd,
    // framer position and events
    input  wire [3:0]  frame_in_mf,
    input  wire [4:0]  timeslot,
    input  wire        crc4_error,
    input  wire        cas_mf_lost,
    input  wire        crc_mf_lost,
    // framer and line interface settings
    output reg         hdb3_enable,
    output reg         framed,
    output reg         cas_enable,
    output reg         crc4_enable,
    output reg  [1:0]  tx_clock_mode,
    output reg  [3:0]  rate_code,
    output reg  [5:0]  user_timeslots,
    output reg         ts16_user,
    output wire        ts0_reserved,
    output wire        ts16_align_insert,
    output wire        loss_of_sync,
    output reg  [15:0] crc_report_count,
    output reg         crc_report_pulse,
    // nonvolatile store
    output reg  [7:0]  nv_save_data,
    output reg         nv_save_pulse
);

    localparam LOGIN_BLANK = 2'h0;
    localparam LOGIN_PASS  = 2'h1;
    localparam LOGIN_MENU  = 2'h2;

    reg  [7:0]  sw_meta;
    reg  [7:0]  sw_sync;
    reg  [7:0]  sw_stable;
    reg  [7:0]  sw_meta_prev;
    reg  [31:0] deb_cnt;
    reg  [7:0]  pending_cfg;
    reg  [7:0]  active_cfg;
    reg  [3:0]  last_rate;
    reg         unsaved;
    reg  [7:0]  pw [0:15];
    reg  [4:0]  pw_len;
    reg  [31:0] stat_cnt;
    reg  [15:0] crc_cnt;
    reg         crc_excess;
    reg  [1:0]  login;
    reg  [4:0]  typed;
    reg         pw_match;
    reg  [15:0] rx_div;
    reg  [3:0]  rx_bit;
    reg  [7:0]  rx_shift;
    reg         rx_busy;
    reg         rx_done;
    reg  [15:0] tx_div;
    reg  [3:0]  tx_bit;
    reg  [9:0]  tx_shift;
    reg         tx_busy;
    reg         tx_hold;
    reg         tx_req;
    reg  [7:0]  tx_char;
    reg  [7:0]  next_cfg;
    reg  [31:0] rd_mux;
    integer     k;

    wire [7:0] sw_raw = {rate_code_bit3, rate_code_bit2, rate_code_bit1, rate_code_bit0,
                         clock_select_switch, crc_or_clock_high_switch,
                         cas_multiframe_switch, line_code_switch};
    wire       wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire       save_cmd = (wr_go && s_axi_awaddr == `REG_COMMAND && s_axi_wstrb[0]
                           && s_axi_wdata[`CMD_SAVE])
                          || (rx_done && login == LOGIN_MENU && rx_shift == `CH_SAVE);
    wire       logoff_cmd = (wr_go && s_axi_awaddr == `REG_COMMAND && s_axi_wstrb[0]
                             && s_axi_wdata[`CMD_LOGOFF])
                            || (rx_done && login == LOGIN_MENU && rx_shift == `CH_LOGOFF);
    wire       pending_wr = wr_go && s_axi_awaddr == `REG_PENDING && s_axi_wstrb[0];

    // write address and data are taken together; answer comes one cycle later
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    // two-stage synchroniser, then a stability window before a change counts
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_meta   <= 8'h00;
            sw_sync   <= 8'h00;
            sw_stable <= 8'h00;
            deb_cnt   <= 32'h0;
        end
        else
        begin
            sw_meta <= sw_raw;
            sw_sync <= sw_meta;
            if (sw_sync == sw_stable)
                deb_cnt <= 32'h0;
            else if (deb_cnt >= DEBOUNCE_CYCLES - 1)
            begin
                sw_stable <= sw_sync;
                deb_cnt   <= 32'h0;
            end
            else
                deb_cnt <= deb_cnt + 32'h1;
        end
    end

    // active set: switches apply at once, the port only at save
    always @*
    begin
        next_cfg = active_cfg;
        if (sw_sync == sw_stable && sw_stable != active_cfg && deb_cnt == 32'h0
            && sw_stable != sw_meta_prev)
            next_cfg = sw_stable;
        if (save_cmd)
            next_cfg = pending_cfg;
    end

    // active and pending sets, save strobe to the store
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_meta_prev <= `CFG_RESET;
            active_cfg   <= `CFG_RESET;
            pending_cfg  <= `CFG_RESET;
            unsaved      <= 1'b0;
            nv_save_pulse <= 1'b0;
            nv_save_data <= 8'h00;
        end
        else
        begin
            sw_meta_prev <= sw_stable;
            // a debounced switch change lands without any save
            if (sw_stable != sw_meta_prev)
                active_cfg <= sw_stable;
            else
                active_cfg <= next_cfg;
            if (pending_wr)
                pending_cfg <= s_axi_wdata[7:0];
            // a new port write in the save cycle stays unsaved
            if (pending_wr)
                unsaved <= 1'b1;
            else if (save_cmd)
                unsaved <= 1'b0;
            nv_save_pulse <= save_cmd;
            if (save_cmd)
                nv_save_data <= pending_cfg;
        end
    end

    // decode of the active setting
    wire [3:0] code_now = active_cfg[`CFG_RATE_LSB+3:`CFG_RATE_LSB];
    wire       rate_bad = (code_now == 4'hf);
    wire [3:0] eff_rate = rate_bad ? last_rate : code_now;
    wire       is_framed = (eff_rate != 4'h0);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_rate      <= 4'h0;
            hdb3_enable    <= 1'b1;
            framed         <= 1'b0;
            cas_enable     <= 1'b0;
            crc4_enable    <= 1'b0;
            tx_clock_mode  <= `CLK_NETWORK;
            rate_code      <= 4'h0;
            user_timeslots <= 6'h20;
            ts16_user      <= 1'b1;
        end
        else
        begin
            last_rate   <= eff_rate;
            rate_code   <= eff_rate;
            hdb3_enable <= !active_cfg[`CFG_LINE_CODE];
            framed      <= is_framed;
            // clear channel ignores both multiframe switches
            cas_enable  <= is_framed && active_cfg[`CFG_CAS];
            crc4_enable <= is_framed && active_cfg[`CFG_CRC_CLK];
            ts16_user   <= !(is_framed && active_cfg[`CFG_CAS]);
            if (is_framed)
                tx_clock_mode <= active_cfg[`CFG_CLK_SEL] ? `CLK_INTERNAL
                                                          : `CLK_NETWORK;
            else
            begin
                case ({active_cfg[`CFG_CRC_CLK], active_cfg[`CFG_CLK_SEL]})
                    2'b01:   tx_clock_mode <= `CLK_INTERNAL;
                    2'b11:   tx_clock_mode <= `CLK_EXTERNAL;
                    default: tx_clock_mode <= `CLK_NETWORK;
                endcase
            end
            // timeslots of 64 kb/s per rate code
            case (eff_rate)
                4'h0:    user_timeslots <= 6'h20;
                4'h1:    user_timeslots <= 6'h01;
                4'h2:    user_timeslots <= 6'h02;
                4'h3:    user_timeslots <= 6'h03;
                4'h4:    user_timeslots <= 6'h04;
                4'h5:    user_timeslots <= 6'h06;
                4'h6:    user_timeslots <= 6'h08;
                4'h7:    user_timeslots <= 6'h0a;
                4'h8:    user_timeslots <= 6'h0c;
                4'h9:    user_timeslots <= 6'h10;
                4'ha:    user_timeslots <= 6'h14;
                4'hb:    user_timeslots <= 6'h18;
                4'hc:    user_timeslots <= 6'h19;
                4'hd:    user_timeslots <= 6'h1e;
                4'he:    user_timeslots <= 6'h1f;
                default: user_timeslots <= 6'h00;
            endcase
        end
    end

    // 31 channels cannot fit once TS16 is withheld
    wire rate_conflict = cas_enable && user_timeslots > 6'h1e;

    // alignment nibble only in frame 0 of 16, timeslot 16 of 0..31
    assign ts16_align_insert = cas_enable && frame_in_mf == 4'h0
                               && timeslot == 5'h10;
    assign ts0_reserved = framed && timeslot == 5'h00;
    // mismatch with the far end shows as lost multiframe alignment
    assign loss_of_sync = (cas_enable && cas_mf_lost)
                          || (crc4_enable && crc_mf_lost);

    // crc-4 error counting, reported to the far end each second
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_cnt         <= 32'h0;
            crc_cnt          <= 16'h0;
            crc_report_count <= 16'h0;
            crc_report_pulse <= 1'b0;
            crc_excess       <= 1'b0;
        end
        else
        begin
            crc_report_pulse <= 1'b0;
            if (stat_cnt >= STATS_CYCLES - 1)
            begin
                stat_cnt         <= 32'h0;
                crc_report_count <= crc_cnt;
                crc_report_pulse <= crc4_enable;
                crc_excess       <= crc_cnt >= CRC_EXCESS;
                crc_cnt          <= {15'h0, crc4_enable && crc4_error};
            end
            else
            begin
                stat_cnt <= stat_cnt + 32'h1;
                if (crc4_enable && crc4_error && crc_cnt != 16'hffff)
                    crc_cnt <= crc_cnt + 16'h1;
            end
        end
    end

    // uart receiver, 8n1, sampled mid bit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_div   <= 16'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
            rx_busy  <= 1'b0;
            rx_done  <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (!rx_busy)
            begin
                if (!ctl_rxd)
                begin
                    rx_busy <= 1'b1;
                    rx_bit  <= 4'h0;
                    rx_div  <= 16'h0;
                end
            end
            else if (rx_div < ((rx_bit == 4'h0) ? `BAUD_DIV / 2 : `BAUD_DIV) - 1)
                rx_div <= rx_div + 16'h1;
            else
            begin
                rx_div <= 16'h0;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && ctl_rxd)
                    rx_busy <= 1'b0;
                else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
                    rx_shift <= {ctl_rxd, rx_shift[7:1]};
                else if (rx_bit == 4'h9)
                begin
                    rx_busy <= 1'b0;
                    rx_done <= ctl_rxd;
                end
            end
        end
    end

    // login session and terminal replies
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            login    <= LOGIN_BLANK;
            typed    <= 5'h00;
            pw_match <= 1'b1;
            tx_req   <= 1'b0;
            tx_char  <= 8'h00;
            tx_hold  <= 1'b0;
        end
        else
        begin
            if (tx_req && !tx_busy && !tx_hold)
                tx_req <= 1'b0;
            if (rx_done && rx_shift == `CH_XOFF)
                tx_hold <= 1'b1;
            else if (rx_done && rx_shift == `CH_XON)
                tx_hold <= 1'b0;
            else if (logoff_cmd)
            begin
                login   <= LOGIN_BLANK;
                tx_char <= `CH_BLANK;
                tx_req  <= 1'b1;
            end
            else if (rx_done)
            begin
                case (login)
                    LOGIN_BLANK:
                    begin
                        if (rx_shift == `CH_ENTER)
                        begin
                            login    <= LOGIN_PASS;
                            typed    <= 5'h00;
                            pw_match <= 1'b1;
                            tx_char  <= `CH_PROMPT;
                            tx_req   <= 1'b1;
                        end
                    end
                    LOGIN_PASS:
                    begin
                        if (rx_shift == `CH_ENTER)
                        begin
                            typed    <= 5'h00;
                            pw_match <= 1'b1;
                            tx_req   <= 1'b1;
                            if (pw_match && typed == pw_len)
                            begin
                                login   <= LOGIN_MENU;
                                tx_char <= `CH_MENU;
                            end
                            else
                                tx_char <= `CH_PROMPT;
                        end
                        else
                        begin
                            // exact byte compare keeps case distinct
                            if (typed >= `PW_MAX || rx_shift != pw[typed[3:0]])
                                pw_match <= 1'b0;
                            if (typed <= `PW_MAX)
                                typed <= typed + 5'h01;
                            tx_char <= `CH_STAR;
                            tx_req  <= 1'b1;
                        end
                    end
                    LOGIN_MENU:
                    begin
                        tx_char <= rx_shift;
                        tx_req  <= 1'b1;
                    end
                    default: login <= LOGIN_BLANK;
                endcase
            end
        end
    end

    // uart transmitter, held off while xoff is in force
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_div   <= 16'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_busy  <= 1'b0;
            ctl_txd  <= 1'b1;
        end
        else if (!tx_busy)
        begin
            ctl_txd <= 1'b1;
            if (tx_req && !tx_hold)
            begin
                tx_busy  <= 1'b1;
                tx_shift <= {1'b1, tx_char, 1'b0};
                tx_bit   <= 4'h0;
                tx_div   <= 16'h0;
            end
        end
        else
        begin
            ctl_txd <= tx_shift[0];
            if (tx_div < `BAUD_DIV - 1)
                tx_div <= tx_div + 16'h1;
            else
            begin
                tx_div   <= 16'h0;
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bit   <= tx_bit + 4'h1;
                if (tx_bit == 4'h9)
                    tx_busy <= 1'b0;
            end
        end
    end

    // password store and bus write response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (k = 0; k < 16; k = k + 1)
                pw[k] <= 8'h00;
            pw_len       <= `DEFAULT_PW_LEN;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr <= `REG_PW_LENGTH)
                                ? 2'h0 : 2'h2;
                for (k = 0; k < 16; k = k + 1)
                    if (s_axi_awaddr == `REG_PW_WORD0 + (k / 4) * 4 && s_axi_wstrb[k % 4])
                        pw[k] <= s_axi_wdata[(k % 4) * 8 +: 8];
                if (s_axi_awaddr == `REG_PW_LENGTH && s_axi_wstrb[0])
                    pw_len <= (s_axi_wdata[4:0] > `PW_MAX) ? 5'h10 : s_axi_wdata[4:0];
            end
        end
    end

    // read mux; password bytes read back as zero
    always @*
    begin
        case (s_axi_araddr)
            `REG_PENDING:  rd_mux = {24'h0, pending_cfg};
            `REG_ACTIVE:   rd_mux = {24'h0, active_cfg};
            `REG_STATUS:   rd_mux = {25'h0, rate_conflict, crc_excess, unsaved,
                                     rate_bad, loss_of_sync, login == LOGIN_BLANK,
                                     login == LOGIN_MENU};
            `REG_CRC_STAT: rd_mux = {16'h0, crc_report_count};
            `REG_PW_LENGTH: rd_mux = {27'h0, pw_len};
            default:       rd_mux = 32'h0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `REG_PW_LENGTH)
                            ? 2'h0 : 2'h2;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// *** e1_cfg_checker.sv ***
`timescale 1ns/1ps
module e1_cfg_checker (
    // clock, reset and watched ports
    input wire       aclk, aresetn, framed, cas_enable, crc4_enable, ts16_user,
    input wire       ts0_reserved, ts16_align_insert, crc_report_pulse,
    input wire       loss_of_sync, cas_mf_lost, crc_mf_lost,
    input wire [3:0] frame_in_mf, rate_code,
    input wire [4:0] timeslot,
    input wire [1:0] tx_clock_mode,
    input wire [5:0] user_timeslots
);
    // one domain; quiet while reset is low
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ts0_slot: assert property (ts0_reserved == (framed && timeslot == 5'h00))
        else $error("ts0 flag");
    a_ts16_align: assert property (ts16_align_insert ==
        (cas_enable && frame_in_mf == 4'h0 && timeslot == 5'h10)) else $error("ts16 align");
    a_clear_all: assert property (!framed |->
        !cas_enable && !crc4_enable && user_timeslots == 6'h20) else $error("clear channel");
    a_ext_unframed: assert property (tx_clock_mode == 2'h2 |-> !framed)
        else $error("external framed");
    a_cas_slots: assert property (framed && cas_enable |-> !ts16_user)
        else $error("ts16 to user");
    a_rate_valid: assert property (rate_code != 4'hf)
        else $error("invalid rate");
    a_framed_rate: assert property (framed |-> rate_code != 4'h0)
        else $error("framed clear");
    a_crc_pulse: assert property (crc_report_pulse |-> $past(crc4_enable) ##1 !crc_report_pulse)
        else $error("crc report");
    a_los_level: assert property (loss_of_sync ==
        ((cas_enable && cas_mf_lost) || (crc4_enable && crc_mf_lost))) else $error("loss of sync");
    // main scenarios
    cover property (framed && cas_enable);
    cover property (tx_clock_mode == 2'h2);
    cover property (crc_report_pulse);
endmodule

bind e1_switch_config_decoder e1_cfg_checker u_chk (.*);

// *** e1_switch_bank.sv ***
`timescale 1ns/1ps
module e1_switch_bank (
    // lever positions asked for
    input  wire [7:0] want,
    // contacts and idle terminal line
    output wire       line_code_switch, cas_multiframe_switch, crc_or_clock_high_switch,
    output wire       clock_select_switch, rate_code_bit0, rate_code_bit1, rate_code_bit2,
    output wire       rate_code_bit3, ctl_rxd
);
    // plain contacts; first rate lever is the code lsb
    assign {rate_code_bit3, rate_code_bit2, rate_code_bit1, rate_code_bit0, clock_select_switch,
            crc_or_clock_high_switch, cas_multiframe_switch, line_code_switch} = want;
    // nobody types, so the line rests at idle mark
    assign ctl_rxd = 1'b1;
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "e1_cfg_defines.vh"
module tb_top;
    // nets named as the ports they meet
    logic        aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, line_code_switch, cas_multiframe_switch, crc_or_clock_high_switch;
    logic        clock_select_switch, rate_code_bit0, rate_code_bit1, rate_code_bit2;
    logic        rate_code_bit3, ctl_rxd, ctl_txd, crc4_error, hdb3_enable, framed, cas_enable;
    logic        crc4_enable, ts16_user, ts0_reserved, ts16_align_insert, loss_of_sync;
    logic        crc_report_pulse, nv_save_pulse, cas_mf_lost, crc_mf_lost;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [15:0] crc_report_count;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, want, nv_save_data, nv_seen;
    // 64k slots per rate code, code 0 last, in the low bits
    logic [89:0] tbl = {6'h1f, 6'h1e, 6'h19, 6'h18, 6'h14, 6'h10, 6'h0c, 6'h0a,
                        6'h08, 6'h06, 6'h04, 6'h03, 6'h02, 6'h01, 6'h20};
    logic [5:0]  user_timeslots;
    logic [4:0]  timeslot;
    logic [3:0]  frame_in_mf, rate_code, rate = 4'h0, s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, tx_clock_mode, rs;
    integer      seed = 32'h3786, n_errors = 0, checks = 0, i;
    wire  [9:0]  seen = {hdb3_enable, framed, cas_enable, crc4_enable, tx_clock_mode, rate_code};

    e1_switch_config_decoder #(.STATS_CYCLES(1000), .DEBOUNCE_CYCLES(8)) u_dut (.*);
    e1_switch_bank u_bank (.*);

    // 100 ns clock; watchdog far beyond the expected run
    initial forever #50 aclk = ~aclk;
    initial #3000000 close_out(1);
    // framer position and error pulses wander
    always @(posedge aclk)
        {cas_mf_lost, crc_mf_lost, crc4_error, frame_in_mf, timeslot} <= 12'($random(seed));
    // last word handed to the store
    always @(posedge aclk)
        if (nv_save_pulse)
            nv_seen <= nv_save_data;

    // expected decode of levers {rate, clock, crc/clock-high, cas, line code}
    function [9:0] ex(input [7:0] s, input [3:0] r);
        ex = {~s[0], |r, |r & s[1], |r & s[2],
              |r ? {1'b0, s[3]} : {s[2] & s[3], ~s[2] & s[3]}, r};
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
            $display("Error %0t: saw %h not %h", $time, got, exp);
        n_errors = n_errors + (got !== exp);
    end
    endtask

    // one axi4-lite transfer; waits on the slave, never on a count
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{~w}};
        @(posedge aclk iff (w ? s_axi_awready : s_axi_arready));
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'b000;
        @(posedge aclk iff (w ? s_axi_bvalid : s_axi_rvalid));
        rs = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'b00;
    end
    endtask

    task close_out(input integer bad);
    begin
        n_errors = n_errors + bad;
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        {aresetn, want, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // random levers, plus all-on and unframed external corners
        for (i = 0; i < 50; i = i + 1)
        begin
            rd = (i == 1) ? 32'hff : (i == 2) ? 32'h0c : $random(seed);
            want <= rd[7:0];
            if (rd[7:4] != 4'hf)
                rate = rd[7:4];
            repeat (20) @(posedge aclk);
            chk(seen, ex(rd[7:0], rate));
            chk(user_timeslots, tbl[rate * 6 +: 6]);
        end
        // software settings wait for save; unmapped place refused
        bus(1, 8'h00, 32'h5a);
        bus(0, 8'h00, 0);
        chk(rd, 32'h5a);
        chk(seen, ex(want, rate));
        bus(1, 8'h0c, 32'h1);
        bus(0, 8'h28, 0);
        chk(rs, 2'h2);
        chk(seen, ex(8'h5a, 4'h5));
        chk(nv_seen, 8'h5a);
        // logoff sends the blanking character, 8n1, lsb first
        bus(1, 8'h0c, 32'h2);
        rd = {22'h0, 1'b1, `CH_BLANK, 1'b0};
        repeat (`BAUD_DIV / 2) @(posedge aclk);
        for (i = 0; i < 10; i = i + 1)
        begin
            chk(ctl_txd, rd[i]);
            repeat (`BAUD_DIV) @(posedge aclk);
        end
        close_out(0);
    end
endmodule
